// ---- hw/bsr_top.sv ----
/*
  Global control registers and self-test receiver of a quad retimer.
  Assumes a byte register port on clk and recovered data already on clk.
*/
`timescale 1ns/1ps
module bsr_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [7:0]                    regAddr,
  input  wire logic                          regWrEn,
  input  wire logic [7:0]                    regWrData,
  input  wire logic                          regRdEn,
  output logic      [7:0]                    regRdData,
  // recovered data from the four channels
  input  wire logic [bsr_pkg::NUM_CHANNELS-1:0] rxBit,
  input  wire logic [bsr_pkg::NUM_CHANNELS-1:0] rxBitValid,
  // user pattern from the pattern registers
  input  wire logic [19:0]                   userPattern,
  // outputs to the rest of the chip
  output logic                               chipSoftReset,
  output logic                               refDivTick,
  output logic                               rxPowered
);
  import bsr_pkg::*;

  logic [7:0]           refCtrl_q;
  logic [7:0]           chanSel_q;
  logic [7:0]           rxCtrl_q;
  logic [7:0]           errCount_q;
  logic                 softRst_q;
  logic [DIV_CNT_W-1:0] divCnt_q;
  logic                 rxEnable;
  logic                 checkerHold;
  logic                 selBit;
  logic                 selValid;
  logic                 errPulse;
  logic                 wrRef;
  logic                 wrChan;
  logic                 wrCtrl;
  logic                 wrErr;

  // ratio minus one, so the counter compares against it directly
  function automatic logic [DIV_CNT_W-1:0] div_last(input logic [2:0] code);
    unique case (code)
      3'h1:    div_last = 6'd1;
      3'h2:    div_last = 6'd3;
      3'h3:    div_last = 6'd7;
      3'h4:    div_last = 6'd11;
      3'h5:    div_last = 6'd15;
      3'h6:    div_last = 6'd31;
      default: div_last = 6'd0;
    endcase
  endfunction : div_last

  assign wrRef  = regWrEn && (regAddr == REF_DIV_CTRL_ADDR);
  assign wrChan = regWrEn && (regAddr == RX_CHAN_SEL_ADDR);
  assign wrCtrl = regWrEn && (regAddr == RX_CTRL_ADDR);
  assign wrErr  = regWrEn && (regAddr == RX_ERR_COUNT_ADDR);
  assign rxEnable = rxCtrl_q[CTRL_EN_BIT];

  // soft reset: one-cycle pulse out, and it also resets these registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) softRst_q <= 1'b0;
    else softRst_q <= regWrEn && (regAddr == MASTER_RESET_ADDR) &&
                      (regWrData == MASTER_RESET_KEY);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) chipSoftReset <= 1'b0;
    else chipSoftReset <= softRst_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) refCtrl_q <= REF_DIV_CTRL_RST;
    else if (softRst_q) refCtrl_q <= REF_DIV_CTRL_RST;
    else if (wrRef) refCtrl_q <= regWrData;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) chanSel_q <= RX_CHAN_SEL_RST;
    else if (softRst_q) chanSel_q <= RX_CHAN_SEL_RST;
    else if (wrChan) chanSel_q <= regWrData;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rxCtrl_q <= RX_CTRL_RST;
    else if (softRst_q) rxCtrl_q <= RX_CTRL_RST;
    else if (wrCtrl) rxCtrl_q <= regWrData;
  end

  // divided tick for acquisition and activity timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q   <= '0;
      refDivTick <= 1'b0;
    end else if (softRst_q) begin
      divCnt_q   <= '0;
      refDivTick <= 1'b0;
    end else if (divCnt_q >= div_last(refCtrl_q[REF_DIV_MSB:REF_DIV_LSB])) begin
      divCnt_q   <= '0;
      refDivTick <= 1'b1;
    end else begin
      divCnt_q   <= divCnt_q + 6'd1;
      refDivTick <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rxPowered <= 1'b0;
    else rxPowered <= rxEnable && !softRst_q;
  end

  // codes with bit 2 set select no channel, so nothing is checked
  always_comb begin
    selBit   = 1'b0;
    selValid = 1'b0;
    if (chanSel_q[CHAN_SEL_MSB] == 1'b0) begin
      selBit   = rxBit[chanSel_q[1:0]];
      selValid = rxBitValid[chanSel_q[1:0]] && rxEnable;
    end
  end

  assign checkerHold = !rxEnable || rxCtrl_q[CTRL_RESET_BIT] || softRst_q;

  bsr_checker u_checker (
    .clk         (clk),
    .rst         (rst),
    .hold        (checkerHold),
    .patt        (bsr_patt_e'(rxCtrl_q[CTRL_PATT_MSB:CTRL_PATT_LSB])),
    .userPattern (userPattern),
    .bitIn       (selBit),
    .bitValid    (selValid),
    .errPulse    (errPulse)
  );

  // clear is a held level, so it wins over a coincident error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) errCount_q <= RX_ERR_COUNT_RST;
    else if (softRst_q) errCount_q <= RX_ERR_COUNT_RST;
    else if (rxEnable && rxCtrl_q[CTRL_CLEAR_BIT]) errCount_q <= RX_ERR_COUNT_RST;
    else if (wrErr) errCount_q <= regWrData;
    else if (errPulse && rxEnable && errCount_q != RX_ERR_COUNT_MAX)
      errCount_q <= errCount_q + 8'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) regRdData <= 8'h00;
    else if (regRdEn) begin
      unique case (regAddr)
        REF_DIV_CTRL_ADDR: regRdData <= refCtrl_q;
        MASTER_RESET_ADDR: regRdData <= MASTER_RESET_READ;
        CHIP_ID_ADDR:      regRdData <= CHIP_ID_VALUE;
        REVISION_ID_ADDR:  regRdData <= REVISION_ID_VALUE;
        RX_CHAN_SEL_ADDR:  regRdData <= chanSel_q;
        RX_CTRL_ADDR:      regRdData <= rxCtrl_q;
        RX_ERR_COUNT_ADDR: regRdData <= errCount_q;
        default:           regRdData <= 8'h00;
      endcase
    end
  end
endmodule : bsr_top

// ---- hw/bsr_pkg.sv ----
/*
  Constants for the global control registers and the self-test receiver.
  Assumes byte-wide register access at the printed offsets.
*/
package bsr_pkg;
  // register offsets
  localparam logic [7:0] REF_DIV_CTRL_ADDR  = 8'h04;
  localparam logic [7:0] MASTER_RESET_ADDR  = 8'h05;
  localparam logic [7:0] CHIP_ID_ADDR       = 8'h06;
  localparam logic [7:0] REVISION_ID_ADDR   = 8'h07;
  localparam logic [7:0] RX_CHAN_SEL_ADDR   = 8'h10;
  localparam logic [7:0] RX_CTRL_ADDR       = 8'h11;
  localparam logic [7:0] RX_ERR_COUNT_ADDR  = 8'h12;
  // reset values, error count limit and soft reset key
  localparam logic [7:0] REF_DIV_CTRL_RST   = 8'h00;
  localparam logic [7:0] MASTER_RESET_READ  = 8'h00;
  localparam logic [7:0] RX_CHAN_SEL_RST    = 8'h00;
  localparam logic [7:0] RX_CTRL_RST        = 8'h01;
  localparam logic [7:0] RX_ERR_COUNT_RST   = 8'h00;
  localparam logic [7:0] RX_ERR_COUNT_MAX   = 8'hFF;
  localparam logic [7:0] MASTER_RESET_KEY   = 8'hAA;
  // identity codes: values are arbitrary
  localparam logic [7:0] CHIP_ID_VALUE      = 8'h5C;
  localparam logic [7:0] REVISION_ID_VALUE  = 8'h01;
  // field positions and sizes
  localparam int REF_DIV_LSB    = 1;
  localparam int REF_DIV_MSB    = 3;
  localparam int CHAN_SEL_MSB   = 2;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_EN_BIT    = 1;
  localparam int CTRL_PATT_LSB  = 2;
  localparam int CTRL_PATT_MSB  = 5;
  localparam int CTRL_CLEAR_BIT = 6;
  localparam int NUM_CHANNELS   = 4;
  localparam int HISTORY_LEN    = 31;
  localparam int DIV_CNT_W      = 6;

  typedef enum logic [3:0] {
    PATT_PRBS7, PATT_PRBS15, PATT_PRBS23, PATT_PRBS31, PATT_FC_JITTER,
    PATT_FC_RANDOM, PATT_COUNTDOWN, PATT_USER16, PATT_USER20
  } bsr_patt_e;

  // stand-in 20-bit reference words for the fixed framed patterns
  localparam logic [19:0] FC_JITTER_WORD = 20'h3E0F8;
  localparam logic [19:0] FC_RANDOM_WORD = 20'hB5A3C;
  localparam logic [19:0] COUNTDOWN_WORD = 20'h17C1A;
endpackage : bsr_pkg

// ---- hw/bsr_checker.sv ----
/*
  Bit checker of the self-test receiver: predicts each received bit from
  the selected pattern and flags a mismatch.
  Assumes one data bit per cycle in which bitValid is high, same clock.
*/
`timescale 1ns/1ps
module bsr_checker (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 hold,
  // pattern choice
  input  wire bsr_pkg::bsr_patt_e   patt,
  input  wire logic [19:0]          userPattern,
  // received stream
  input  wire logic                 bitIn,
  input  wire logic                 bitValid,
  // result
  output logic                      errPulse
);
  import bsr_pkg::*;

  logic [HISTORY_LEN-1:0] hist_q;
  logic [4:0]             fill_q;
  logic [19:0]            ref_q;
  logic [4:0]             refIdx_q;
  logic                   isPrbs;
  logic                   predicted;
  logic                   histFull;
  logic [4:0]             period;
  logic [4:0]             order;

  // pattern word and its length for the framed patterns
  function automatic logic [19:0] ref_word(input bsr_patt_e p, input logic [19:0] u);
    unique case (p)
      PATT_FC_JITTER: ref_word = FC_JITTER_WORD;
      PATT_FC_RANDOM: ref_word = FC_RANDOM_WORD;
      PATT_COUNTDOWN: ref_word = COUNTDOWN_WORD;
      PATT_USER16:    ref_word = {u[15:0], 4'h0};
      default:        ref_word = u;
    endcase
  endfunction : ref_word

  always_comb begin
    isPrbs    = (patt == PATT_PRBS7) || (patt == PATT_PRBS15) ||
                (patt == PATT_PRBS23) || (patt == PATT_PRBS31);
    period    = (patt == PATT_USER16) ? 5'd16 : 5'd20;
    predicted = ref_q[5'd19 - refIdx_q];
    order     = 5'd7;
    unique case (patt)
      PATT_PRBS7: begin
        predicted = hist_q[6] ^ hist_q[5];
        order     = 5'd7;
      end
      PATT_PRBS15: begin
        predicted = hist_q[14] ^ hist_q[13];
        order     = 5'd15;
      end
      PATT_PRBS23: begin
        predicted = hist_q[22] ^ hist_q[17];
        order     = 5'd23;
      end
      PATT_PRBS31: begin
        predicted = hist_q[30] ^ hist_q[27];
        order     = 5'd31;
      end
      default: begin
      end
    endcase
    histFull = (fill_q >= order);
  end

  // self-synchronising: history seeds from the line, no error until full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_q <= '0;
      fill_q <= '0;
    end else if (hold) begin
      hist_q <= '0;
      fill_q <= '0;
    end else if (bitValid) begin
      hist_q <= {hist_q[HISTORY_LEN-2:0], bitIn};
      if (fill_q != 5'd31) fill_q <= fill_q + 5'd1;
    end
  end

  // framed patterns assume alignment from the release of hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_q    <= '0;
      refIdx_q <= '0;
    end else if (hold) begin
      ref_q    <= ref_word(patt, userPattern);
      refIdx_q <= '0;
    end else if (bitValid && !isPrbs) begin
      refIdx_q <= (refIdx_q == period - 5'd1) ? 5'd0 : refIdx_q + 5'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) errPulse <= 1'b0;
    else errPulse <= !hold && bitValid && (!isPrbs || histFull) && (bitIn != predicted);
  end
endmodule : bsr_checker

// ---- dv/bsr_top_sva.sv ----
/* Checker for the bsr_top register port and soft reset output.
   Assumes one clock domain; bound to every bsr_top below. */
`timescale 1ns/1ps
module bsr_top_sva
  import bsr_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  // chip output
  input wire logic       chipSoftReset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic keyWr;
  assign keyWr = regWrEn && regAddr == MASTER_RESET_ADDR && regWrData == MASTER_RESET_KEY;

  a_chip_id_read: assert property (
    regRdEn && regAddr == CHIP_ID_ADDR ##1 !regRdEn |=> regRdData == CHIP_ID_VALUE)
    else $error("chip id read wrong");
  a_rev_id_read: assert property (
    regRdEn && regAddr == REVISION_ID_ADDR ##1 !regRdEn |=> regRdData == REVISION_ID_VALUE)
    else $error("revision read wrong");
  a_mreset_reads_zero: assert property (
    regRdEn && regAddr == MASTER_RESET_ADDR ##1 !regRdEn |=> regRdData == 8'h00)
    else $error("master reset read not zero");
  a_key_fires_reset: assert property (keyWr |-> ##[1:3] chipSoftReset)
    else $error("soft reset missing");
  a_reset_needs_key: assert property (
    chipSoftReset |-> $past(keyWr, 2) || $past(keyWr, 3))
    else $error("soft reset without key");
  a_reset_pulse_single: assert property (chipSoftReset |=> !chipSoftReset)
    else $error("soft reset too long");
  a_rdata_holds: assert property (!regRdEn ##1 !regRdEn |=> $stable(regRdData))
    else $error("read data moved");
  a_chan_readback: assert property (
    regWrEn && regAddr == RX_CHAN_SEL_ADDR ##1 !regWrEn
    ##1 regRdEn && regAddr == RX_CHAN_SEL_ADDR ##1 !regRdEn
    |=> regRdData == $past(regWrData, 4))
    else $error("channel select readback wrong");

  c_soft_reset: cover property (chipSoftReset);
  c_key_write: cover property (keyWr);
  c_count_read: cover property (regRdEn && regAddr == RX_ERR_COUNT_ADDR);
endmodule : bsr_top_sva

bind bsr_top bsr_top_sva u_bsr_top_sva (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .chipSoftReset(chipSoftReset));

// ---- dv/bsr_cdr_model.sv ----
/* Four recovered-data channels feeding the self-test receiver.
   Assumes run and the stream settings change away from the rising edge. */
`timescale 1ns/1ps
module bsr_cdr_model (
  // clock
  input  wire logic        clk,
  // stream settings
  input  wire logic        run,
  input  wire logic        slow,
  input  wire logic        prbs,
  input  wire logic [1:0]  chan,
  input  wire logic [4:0]  len,
  input  wire logic [19:0] word,
  input  wire logic [7:0]  nErr,
  // recovered channels
  output logic      [3:0]  rxBit,
  output logic      [3:0]  rxBitValid
);
  int         idx;
  int         left;
  int         nb;
  logic       b;
  logic       flip;
  logic [6:0] ps;
  logic       ph = 1'b0;

  initial rxBit = '0;
  initial rxBitValid = '0;

  always @(posedge clk) begin
    ph = ~ph;
    if (!run || (slow && ph)) begin
      rxBitValid <= '0;
      // idle line keeps no stale bit
      rxBit <= ~rxBit;
      if (!run) begin
        idx = len - 1;
        left = nErr;
        nb = 0;
        ps = 7'h7F;
      end
    end else begin
      // x^7+x^6 sequence; its errors land after the checker has locked
      b = prbs ? (ps[6] ^ ps[5]) : word[idx];
      ps = {ps[5:0], b};
      flip = (left > 0) && (!prbs || nb == 20);
      if (flip) left--;
      nb++;
      idx = (idx == 0) ? len - 1 : idx - 1;
      // unselected channels carry the inverse, so a wrong pick counts
      rxBit <= {4{~(b ^ flip)}} ^ (4'h1 << chan);
      rxBitValid <= '1;
    end
  end
endmodule : bsr_cdr_model

// ---- dv/tb_bist_receiver_and_global_ctrl.sv ----
/* Self-checking bench for bsr_top: register map, divider, soft reset, error count.
   Assumes bsr_cdr_model on the channels and the bound checker. */
`timescale 1ns/1ps
module tb_bist_receiver_and_global_ctrl;
  import bsr_pkg::*;
  logic        clk = 1'b0;
  logic        rst, regWrEn, regRdEn, chipSoftReset, refDivTick, rxPowered, run, slow, prbs;
  logic [7:0]  regAddr, regWrData, regRdData, nErr, pre;
  logic [3:0]  rxBit, rxBitValid;
  logic [19:0] userPattern;
  logic [1:0]  chan;
  logic [4:0]  len;
  logic [31:0] seed;
  logic [15:0] rstTab [8];
  int          err_total, check_count, n;

  always #5 clk = ~clk;

  bsr_top u_bsr_top (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .userPattern(userPattern), .chipSoftReset(chipSoftReset),
    .refDivTick(refDivTick), .rxPowered(rxPowered));
  bsr_cdr_model u_bsr_cdr_model (.clk(clk), .run(run), .slow(slow), .prbs(prbs),
    .chan(chan), .len(len), .word(userPattern), .nErr(nErr), .rxBit(rxBit),
    .rxBitValid(rxBitValid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int ratio(input int c);
    return (c == 4) ? 12 : (c == 5) ? 16 : (c == 6) ? 32 : (1 << c);
  endfunction : ratio

  function automatic logic [7:0] sat(input int s);
    return (s > 255) ? 8'hFF : 8'(s);
  endfunction : sat

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), e, regRdData);
  endtask : rdc

  task automatic stream(input logic [3:0] p);
    wr(RX_CHAN_SEL_ADDR, {6'h00, chan});
    rdc(RX_CHAN_SEL_ADDR, {6'h00, chan});
    wr(RX_CTRL_ADDR, {2'b01, p, 2'b11});
    wr(RX_CTRL_ADDR, {2'b00, p, 2'b10});
    if (pre != 8'h00) wr(RX_ERR_COUNT_ADDR, pre);
    run = 1'b1;
    repeat (70) @(negedge clk);
    run = 1'b0;
    repeat (4) @(negedge clk);
  endtask : stream

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {regAddr, regWrData, regWrEn, regRdEn, userPattern, run, slow, chan, nErr, pre} = '0;
    prbs = 1'b0;
    len = 5'd20;
    seed = 32'd33;
    err_total = 0;
    check_count = 0;
    rstTab = '{16'h0400, 16'h0500, {CHIP_ID_ADDR, CHIP_ID_VALUE}, 16'h1000, 16'h1101,
      {REVISION_ID_ADDR, REVISION_ID_VALUE}, 16'h1200, 16'h2000};
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (rstTab[i]) rdc(rstTab[i][15:8], rstTab[i][7:0]);
    repeat (4) begin
      n = rnd();
      wr(REF_DIV_CTRL_ADDR, 8'(n));
      wr(MASTER_RESET_ADDR, 8'(n) | 8'h01);
      rdc(MASTER_RESET_ADDR, 8'h00);
      rdc(REF_DIV_CTRL_ADDR, 8'(n));
      wr(REVISION_ID_ADDR, 8'(n));
      rdc(REVISION_ID_ADDR, REVISION_ID_VALUE);
    end
    for (int c = 0; c < 7; c++) begin
      wr(REF_DIV_CTRL_ADDR, 8'(c << 1));
      repeat (40) @(negedge clk);
      n = 0;
      repeat (96) begin
        @(negedge clk);
        n += int'(refDivTick === 1'b1);
      end
      chk("tick", 8'(96 / ratio(c)), 8'(n));
    end
    for (int t = 0; t < 13; t++) begin
      chan = 2'(t);
      slow = 1'(rnd());
      len = (t == 8) ? 5'd16 : 5'd20;
      userPattern = (t == 9) ? FC_JITTER_WORD : (t == 10) ? FC_RANDOM_WORD :
        (t == 11) ? COUNTDOWN_WORD : 20'(rnd());
      prbs = (t == 12);
      nErr = (t == 5) ? 8'd5 : (t == 12) ? 8'd1 : 8'(rnd() % 6);
      pre = (t == 5) ? 8'hFD : 8'h00;
      stream((t == 8) ? 4'h7 : (t == 12) ? 4'h0 : (t > 8) ? 4'(t - 5) : 4'h8);
      chk("powered", 8'h01, {7'h00, rxPowered});
      // one flipped bit of a self-synchronising sequence is seen three times
      rdc(RX_ERR_COUNT_ADDR, prbs ? 8'h03 : sat(pre + nErr));
    end
    prbs = 1'b0;
    wr(RX_CTRL_ADDR, 8'h62);
    rdc(RX_ERR_COUNT_ADDR, 8'h00);
    wr(RX_CTRL_ADDR, 8'h20);
    nErr = 8'd3;
    run = 1'b1;
    repeat (30) @(negedge clk);
    run = 1'b0;
    chk("powered", 8'h00, {7'h00, rxPowered});
    rdc(RX_ERR_COUNT_ADDR, 8'h00);
    wr(RX_CHAN_SEL_ADDR, 8'h03);
    wr(MASTER_RESET_ADDR, MASTER_RESET_KEY);
    n = 0;
    repeat (6) begin
      @(negedge clk);
      n += int'(chipSoftReset === 1'b1);
    end
    chk("softreset", 8'h01, 8'(n));
    foreach (rstTab[i]) rdc(rstTab[i][15:8], rstTab[i][7:0]);
    wrap_up();
  end
endmodule : tb_bist_receiver_and_global_ctrl
